/* core/lic_fifo.sv */
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
module lic_fifo #(
	parameter int WIDTH = 37,
	parameter int DEPTH = 4
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_C = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_P = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [CW-1:0] count_r;
	logic do_wr;
	logic do_rd;

	assign in_ready_o = (count_r != FULL_C);
	assign out_valid_o = (count_r != '0);
	assign out_data_o = mem[rd_ptr_r];
	assign do_wr = in_valid_i && in_ready_o;
	assign do_rd = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i) begin
		if (do_wr) begin
			mem[wr_ptr_r] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_r <= (wr_ptr_r == LAST_P) ? '0 : PW'(wr_ptr_r + 1'b1);
			end
			if (do_rd) begin
				rd_ptr_r <= (rd_ptr_r == LAST_P) ? '0 : PW'(rd_ptr_r + 1'b1);
			end
			if (do_wr && !do_rd) begin
				count_r <= CW'(count_r + 1'b1);
			end else if (do_rd && !do_wr) begin
				count_r <= CW'(count_r - 1'b1);
			end
		end
	end

endmodule : lic_fifo

/* core/lic_pkg.sv */
/*
 Constants, opcode values and carrier types of the lossless image compressor.
 Assumes nothing of its surroundings; imported by lic_top but not by lic_fifo.
*/
package lic_pkg;

	localparam int PIX_W = 24;
	localparam int COMP_W = 8;
	localparam int WORD_W = 32;
	localparam int LANES = 4;
	localparam int FIFO_DEPTH = 4;

	// Start-up cycles waited before the first pixel request
	localparam int INIT_CYCLES = 62;
	localparam logic [5:0] INIT_LAST = 6'(INIT_CYCLES - 1);

	// Cache geometry and hash weights
	localparam int CACHE_ENTRIES = 64;
	localparam int IDX_W = 6;
	localparam logic [7:0] HASH_WR = 8'h03;
	localparam logic [7:0] HASH_WG = 8'h05;
	localparam logic [7:0] HASH_WB = 8'h07;
	// 11 * 255 mod 64, alpha fixed opaque
	localparam logic [7:0] HASH_ALPHA = 8'h35;

	// Opcode tags
	localparam logic [1:0] OP_INDEX = 2'h0;
	localparam logic [1:0] OP_DIFF = 2'h1;
	localparam logic [1:0] OP_LUMA = 2'h2;
	localparam logic [1:0] OP_RUN = 2'h3;
	localparam logic [7:0] OP_RGB = 8'hFE;

	// Run and difference limits
	localparam logic [5:0] RUN_MAX = 6'h3E;
	localparam int DIFF_LO = -2;
	localparam int DIFF_HI = 1;
	localparam logic [7:0] DIFF_BIAS = 8'h02;
	localparam int LUMA_G_LO = -32;
	localparam int LUMA_G_HI = 31;
	localparam logic [7:0] LUMA_G_BIAS = 8'h20;
	localparam int LUMA_RB_LO = -8;
	localparam int LUMA_RB_HI = 7;
	localparam logic [7:0] LUMA_RB_BIAS = 8'h08;

	// Byte accumulator
	localparam int ACC_BYTES = 12;
	localparam int ACC_W = ACC_BYTES * 8;
	localparam int ENC_BYTES = 5;
	localparam int ENC_W = ENC_BYTES * 8;
	localparam logic [3:0] LANES_C = 4'h4;

	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} lic_pixel_t;

	localparam lic_pixel_t PREV_INIT = '{red: 8'h00, green: 8'h00, blue: 8'h00};

	typedef struct packed {
		logic [WORD_W-1:0] data;
		logic [LANES-1:0] strb;
		logic last;
	} lic_word_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_INIT = 2'b01,
		ST_RUN = 2'b10,
		ST_FLUSH = 2'b11
	} lic_state_t;

endpackage : lic_pkg

/* core/lic_top.sv */
/*
 Streaming lossless RGB compressor: pixel in, byte-packed opcode stream out.
 Assumes pixel source and consumer share CLK_I and stall the core through EN_I.
*/
`timescale 1ns/100ps
module lic_top
	import lic_pkg::*;
#(
	parameter int FIFO_DEPTH_P = lic_pkg::FIFO_DEPTH
) (
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire logic EN_I,
	input wire logic START_I,
	input wire logic [lic_pkg::COMP_W-1:0] RED_I,
	input wire logic [lic_pkg::COMP_W-1:0] GREEN_I,
	input wire logic [lic_pkg::COMP_W-1:0] BLUE_I,
	input wire logic FINAL_PIXEL_IN_I,
	output logic PIXEL_REQ_O,
	output logic [lic_pkg::WORD_W-1:0] DOUT_O,
	output logic [lic_pkg::LANES-1:0] VALID_O,
	output logic FINAL_WORD_FLAG_O
);
	import lic_pkg::*;

	lic_state_t state_r;
	logic [5:0] init_cnt_r;
	logic req_r;
	logic adv;
	logic take;

	// Input stage
	lic_pixel_t s_px_r;
	logic s_vld_r;
	logic s_last_r;

	// Encoder state
	lic_pixel_t prev_r;
	logic [5:0] run_r;
	logic [5:0] run_nxt;
	logic [CACHE_ENTRIES-1:0] cache_vld_r;
	lic_pixel_t cache_mem [CACHE_ENTRIES];

	// Encoder outputs
	logic [IDX_W-1:0] idx;
	logic [7:0] hsum;
	logic cache_hit;
	logic cache_wr;
	logic [7:0] dr;
	logic [7:0] dg;
	logic [7:0] db;
	logic [7:0] dgr;
	logic [7:0] dgb;
	logic pre_en;
	logic [7:0] pre_byte;
	logic [31:0] pix_bytes;
	logic [2:0] pix_cnt;
	logic [ENC_W-1:0] enc_bytes;
	logic [3:0] enc_cnt;
	logic encoding;

	// Packer
	logic [ACC_W-1:0] acc_r;
	logic [3:0] cnt_r;
	logic [ACC_W-1:0] merged;
	logic [3:0] total;
	logic total_gt4;

	// FIFO interface
	lic_word_t push_word;
	logic push;
	logic fifo_in_ready;
	logic fifo_out_valid;
	lic_word_t fifo_out;

	// Output registers
	logic [WORD_W-1:0] dout_r;
	logic [LANES-1:0] valid_r;
	logic last_r;

	function automatic logic [LANES-1:0] strb_of(input logic [3:0] n);
		logic [LANES-1:0] s;
		s = '0;
		for (int i = 0; i < LANES; i++) begin
			if (n > 4'(i)) begin
				s[LANES-1-i] = 1'b1;
			end
		end
		return s;
	endfunction : strb_of

	function automatic logic in_range(input logic [7:0] v, input int lo, input int hi);
		int sv;
		sv = int'($signed(v));
		return (sv >= lo) && (sv <= hi);
	endfunction : in_range

	// A full FIFO stalls the core like EN_I does, but PIXEL_REQ_O stays high, so a pixel offered then is dropped
	assign adv = EN_I && fifo_in_ready;
	assign take = adv && req_r && (state_r == ST_RUN);
	assign encoding = (state_r == ST_RUN) && s_vld_r;

	// Control
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			state_r <= ST_IDLE;
			init_cnt_r <= '0;
			req_r <= 1'b0;
		end else if (adv) begin
			unique case (state_r)
				ST_IDLE: begin
					if (START_I) begin
						state_r <= ST_INIT;
						init_cnt_r <= '0;
					end
				end
				ST_INIT: begin
					init_cnt_r <= 6'(init_cnt_r + 1'b1);
					if (init_cnt_r == INIT_LAST) begin
						state_r <= ST_RUN;
						req_r <= 1'b1;
					end
				end
				ST_RUN: begin
					if (take && FINAL_PIXEL_IN_I) begin
						req_r <= 1'b0;
					end
					if (s_vld_r && s_last_r) begin
						state_r <= total_gt4 ? ST_FLUSH : ST_IDLE;
					end
				end
				ST_FLUSH: begin
					if (cnt_r <= LANES_C) begin
						state_r <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Input stage
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			s_px_r <= PREV_INIT;
			s_vld_r <= 1'b0;
			s_last_r <= 1'b0;
		end else if (adv) begin
			s_vld_r <= take;
			if (take) begin
				s_px_r <= '{red: RED_I, green: GREEN_I, blue: BLUE_I};
				s_last_r <= FINAL_PIXEL_IN_I;
			end
		end
	end

	// Cache hash with opaque alpha
	assign hsum = 8'(s_px_r.red * HASH_WR + s_px_r.green * HASH_WG + s_px_r.blue * HASH_WB + HASH_ALPHA);
	assign idx = hsum[IDX_W-1:0];
	assign cache_hit = cache_vld_r[idx] && (cache_mem[idx] == s_px_r);
	assign dr = 8'(s_px_r.red - prev_r.red);
	assign dg = 8'(s_px_r.green - prev_r.green);
	assign db = 8'(s_px_r.blue - prev_r.blue);
	assign dgr = 8'(dr - dg);
	assign dgb = 8'(db - dg);

	// Opcode selection; no header or end marker is ever produced
	always_comb begin
		pre_en = 1'b0;
		pre_byte = '0;
		pix_bytes = '0;
		pix_cnt = '0;
		run_nxt = run_r;
		cache_wr = 1'b0;
		if (s_px_r == prev_r) begin
			run_nxt = 6'(run_r + 1'b1);
			if ((run_nxt == RUN_MAX) || s_last_r) begin
				pix_bytes = {OP_RUN, run_r, 24'h000000};
				pix_cnt = 3'h1;
				run_nxt = '0;
			end
		end else begin
			run_nxt = '0;
			if (run_r != '0) begin
				pre_en = 1'b1;
				pre_byte = {OP_RUN, 6'(run_r - 1'b1)};
			end
			if (cache_hit) begin
				pix_bytes = {OP_INDEX, idx, 24'h000000};
				pix_cnt = 3'h1;
			end else begin
				cache_wr = 1'b1;
				if (in_range(dr, DIFF_LO, DIFF_HI) && in_range(dg, DIFF_LO, DIFF_HI)
						&& in_range(db, DIFF_LO, DIFF_HI)) begin
					pix_bytes = {OP_DIFF, 2'(dr + DIFF_BIAS), 2'(dg + DIFF_BIAS), 2'(db + DIFF_BIAS), 24'h000000};
					pix_cnt = 3'h1;
				end else if (in_range(dg, LUMA_G_LO, LUMA_G_HI) && in_range(dgr, LUMA_RB_LO, LUMA_RB_HI)
						&& in_range(dgb, LUMA_RB_LO, LUMA_RB_HI)) begin
					pix_bytes = {OP_LUMA, 6'(dg + LUMA_G_BIAS), 4'(dgr + LUMA_RB_BIAS), 4'(dgb + LUMA_RB_BIAS), 16'h0000};
					pix_cnt = 3'h2;
				end else begin
					pix_bytes = {OP_RGB, s_px_r.red, s_px_r.green, s_px_r.blue};
					pix_cnt = 3'h4;
				end
			end
		end
	end

	// A pending run byte precedes the pixel's own bytes
	assign enc_bytes = pre_en ? {pre_byte, pix_bytes} : {pix_bytes, 8'h00};
	assign enc_cnt = 4'(pix_cnt) + 4'(pre_en);

	// Encoder state
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			prev_r <= PREV_INIT;
			run_r <= '0;
			cache_vld_r <= '0;
		end else if (adv) begin
			if (state_r == ST_IDLE && START_I) begin
				// Flagging entries invalid equals zeroing them: no opaque pixel matches zero alpha
				prev_r <= PREV_INIT;
				run_r <= '0;
				cache_vld_r <= '0;
			end else if (encoding) begin
				prev_r <= s_px_r;
				run_r <= run_nxt;
				if (cache_wr) begin
					cache_vld_r[idx] <= 1'b1;
				end
			end
		end
	end

	// Entry contents need no reset, the valid flags guard them
	always_ff @(posedge CLK_I) begin
		if (adv && encoding && cache_wr) begin
			cache_mem[idx] <= s_px_r;
		end
	end

	// Packer: earliest byte lands highest
	assign merged = acc_r | ({enc_bytes, {(ACC_W - ENC_W){1'b0}}} >> {cnt_r, 3'h0});
	assign total = 4'(cnt_r + enc_cnt);
	assign total_gt4 = (total > LANES_C);

	always_comb begin
		push = 1'b0;
		push_word = '0;
		if (encoding) begin
			push = (total >= LANES_C) || s_last_r;
			push_word.data = merged[ACC_W-1 -: WORD_W];
			push_word.strb = strb_of(total);
			push_word.last = s_last_r && !total_gt4;
		end else if (state_r == ST_FLUSH) begin
			push = 1'b1;
			push_word.data = acc_r[ACC_W-1 -: WORD_W];
			push_word.strb = strb_of(cnt_r);
			push_word.last = (cnt_r <= LANES_C);
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			acc_r <= '0;
			cnt_r <= '0;
		end else if (adv) begin
			if (encoding) begin
				if (push) begin
					acc_r <= merged << WORD_W;
					cnt_r <= total_gt4 ? 4'(total - LANES_C) : '0;
				end else begin
					acc_r <= merged;
					cnt_r <= total;
				end
			end else if (state_r == ST_FLUSH) begin
				acc_r <= acc_r << WORD_W;
				cnt_r <= (cnt_r > LANES_C) ? 4'(cnt_r - LANES_C) : '0;
			end
		end
	end

	lic_fifo #(
		.WIDTH($bits(lic_word_t)),
		.DEPTH(FIFO_DEPTH_P)
	) u_fifo (
		.clk_i(CLK_I),
		.rst_n_i(RESETN_I),
		.in_valid_i(push && EN_I),
		.in_data_i(push_word),
		.in_ready_o(fifo_in_ready),
		.out_valid_o(fifo_out_valid),
		.out_data_o(fifo_out),
		.out_ready_i(EN_I)
	);

	// Output registers hold while stalled
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			dout_r <= '0;
			valid_r <= '0;
			last_r <= 1'b0;
		end else if (EN_I) begin
			if (fifo_out_valid) begin
				dout_r <= fifo_out.data;
				valid_r <= fifo_out.strb;
				last_r <= fifo_out.last;
			end else begin
				valid_r <= '0;
				last_r <= 1'b0;
			end
		end
	end

	assign PIXEL_REQ_O = req_r;
	assign DOUT_O = dout_r;
	assign VALID_O = valid_r;
	assign FINAL_WORD_FLAG_O = last_r;

endmodule : lic_top

/* tb/lic_stream_partner.sv */
/*
 Pixel source and word sink facing the compressor, sharing its enable.
 Assumes a six-pixel image held steady by the bench.
*/
`timescale 1ns/100ps
module lic_stream_partner
	import lic_pkg::*;
(
	input wire logic clk_i,
	input wire logic req_i,
	input wire logic stall_i,
	input wire lic_pixel_t [5:0] img_i,
	output logic en_o,
	output lic_pixel_t pix_o,
	output logic final_o
);
	int idx = 0;
	logic ph = 1'b0;
	logic take;
	initial begin
		en_o = 1'b1;
		pix_o = '0;
		final_o = 1'b0;
	end
	always @(negedge clk_i) begin
		ph = !ph;
		// Stalls only while pixels are owed, so the flush is seen unstalled
		en_o = !(stall_i && req_i && ph);
		take = req_i && en_o;
		// Garbage when nothing is taken, since the core must ignore it
		pix_o = take ? img_i[idx] : ~img_i[idx];
		final_o = take ? (idx == 5) : !en_o;
	end
	always @(posedge clk_i) begin
		idx <= !req_i ? 0 : idx + (en_o ? 1 : 0);
	end
endmodule : lic_stream_partner

/* tb/lic_top_properties.sv */
/*
 Port checks of the compressor.
 Assumes EN_I high from start until demand rises and after the final pixel.
*/
`timescale 1ns/100ps
module lic_top_properties
	import lic_pkg::*;
#(
	parameter int FIFO_DEPTH_P = 4
) (
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire logic EN_I,
	input wire logic START_I,
	input wire logic [7:0] RED_I,
	input wire logic [7:0] GREEN_I,
	input wire logic [7:0] BLUE_I,
	input wire logic FINAL_PIXEL_IN_I,
	input wire logic PIXEL_REQ_O,
	input wire logic [31:0] DOUT_O,
	input wire logic [3:0] VALID_O,
	input wire logic FINAL_WORD_FLAG_O
);
	logic armed_r;
	logic [7:0] wait_r;
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			armed_r <= 1'b0;
		end else if (START_I && EN_I && !armed_r) begin
			armed_r <= 1'b1;
		end else if (FINAL_WORD_FLAG_O && EN_I) begin
			armed_r <= 1'b0;
		end
	end
	// Saturates so a long flush cannot wrap it back to the init figure
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			wait_r <= 8'h00;
		end else if (START_I && EN_I && !armed_r) begin
			wait_r <= 8'h00;
		end else if (armed_r && EN_I && !PIXEL_REQ_O && wait_r != 8'hFF) begin
			wait_r <= wait_r + 8'h01;
		end
	end
	a_init_len: assert property ($rose(PIXEL_REQ_O) |-> wait_r == 8'h3E)
		else $error("demand rose after a wrong wait");
	a_stall_freeze: assert property (!EN_I |=> $stable(DOUT_O) && $stable(VALID_O)
		&& $stable(FINAL_WORD_FLAG_O) && $stable(PIXEL_REQ_O)) else $error("outputs moved while stalled");
	a_req_gapless: assert property (PIXEL_REQ_O && !(EN_I && FINAL_PIXEL_IN_I) |=> PIXEL_REQ_O)
		else $error("demand dropped early");
	a_req_drop: assert property (PIXEL_REQ_O && EN_I && FINAL_PIXEL_IN_I |=> !PIXEL_REQ_O)
		else $error("demand stayed after final pixel");
	a_flush_bound: assert property (PIXEL_REQ_O && EN_I && FINAL_PIXEL_IN_I |-> ##[1:9] FINAL_WORD_FLAG_O)
		else $error("final word late");
	a_word_full: assert property (VALID_O != 4'h0 && !FINAL_WORD_FLAG_O |-> VALID_O == 4'hF)
		else $error("partial word before the end");
	a_last_lanes: assert property (FINAL_WORD_FLAG_O |-> VALID_O inside {4'h8, 4'hC, 4'hE, 4'hF})
		else $error("bad strobes on final word");
	a_idle_quiet: assert property (!armed_r |-> VALID_O == 4'h0 && !PIXEL_REQ_O)
		else $error("output outside an image");
endmodule : lic_top_properties

bind lic_top lic_top_properties #(.FIFO_DEPTH_P(FIFO_DEPTH_P)) i_props (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
	.EN_I(EN_I), .START_I(START_I), .RED_I(RED_I), .GREEN_I(GREEN_I), .BLUE_I(BLUE_I),
	.FINAL_PIXEL_IN_I(FINAL_PIXEL_IN_I), .PIXEL_REQ_O(PIXEL_REQ_O), .DOUT_O(DOUT_O), .VALID_O(VALID_O),
	.FINAL_WORD_FLAG_O(FINAL_WORD_FLAG_O));

/* tb/lic_top_tb.sv */
/*
 Self-checking bench: init wait, async reset, encoding, packing, stalls.
 Assumes the partner model supplies pixels and enable.
*/
`timescale 1ns/100ps
module lic_top_tb;
	import lic_pkg::*;
	logic CLK_I = 1'b0;
	logic RESETN_I = 1'b0;
	logic START_I = 1'b0;
	logic stall = 1'b0;
	logic en, fin, req, flag;
	lic_pixel_t pix;
	// RGB, diff, luma, then index and a run of two
	lic_pixel_t [5:0] img = {{3{24'h0A141E}}, 24'h151F29, 24'h0B151F, 24'h0A141E};
	logic [WORD_W-1:0] dout;
	logic [LANES-1:0] vld;
	int fails = 0;
	int check_count = 0;
	int n;
	lic_word_t got[$];
	always #25 CLK_I = !CLK_I;
	lic_top i_dut (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .EN_I(en), .START_I(START_I), .RED_I(pix.red),
		.GREEN_I(pix.green), .BLUE_I(pix.blue), .FINAL_PIXEL_IN_I(fin), .PIXEL_REQ_O(req), .DOUT_O(dout),
		.VALID_O(vld), .FINAL_WORD_FLAG_O(flag));
	lic_stream_partner i_src (.clk_i(CLK_I), .req_i(req), .stall_i(stall), .img_i(img), .en_o(en),
		.pix_o(pix), .final_o(fin));
	always @(posedge CLK_I) begin
		if (en && vld !== 4'h0) got.push_back('{dout, vld, flag});
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop
	task automatic pulse_start;
		@(negedge CLK_I);
		START_I = 1'b1;
		@(negedge CLK_I);
		START_I = 1'b0;
	endtask : pulse_start
	task automatic test_init_reset;
		pulse_start();
		for (n = 0; n < 200 && !req; n++) @(negedge CLK_I);
		check(n, 62);
		// Dropped and checked between two rising edges, so only the asynchronous path can clear it
		@(negedge CLK_I);
		RESETN_I = 1'b0;
		#2 check({req, vld, flag, dout}, '0);
		repeat (5) @(negedge CLK_I);
		RESETN_I = 1'b1;
		got.delete();
		$display("test init_reset done");
	endtask : test_init_reset
	task automatic test_image(input logic stalled);
		stall = stalled;
		got.delete();
		pulse_start();
		for (n = 0; n < 400 && !(got.size() > 0 && got[$].last); n++) @(negedge CLK_I);
		repeat (12) @(negedge CLK_I);
		check(got.size(), 3);
		check(got[0], {32'hFE0A141E, 4'hF, 1'b0});
		check(got[1], {32'h7FAA8809, 4'hF, 1'b0});
		check({got[2].data[31:24], got[2].strb, got[2].last}, {8'hC1, 4'h8, 1'b1});
		$display("test image stalled=%0b done", stalled);
	endtask : test_image
	initial begin
		repeat (5) @(negedge CLK_I);
		RESETN_I = 1'b1;
		test_init_reset();
		test_image(1'b0);
		test_image(1'b1);
		report_and_stop();
	end
	// Whole run needs about 250 cycles; allow eight times that
	initial begin
		#100000;
		fails++;
		report_and_stop();
	end
endmodule : lic_top_tb
